//--- design/audio_fifo_pkg.sv
package audio_fifo_pkg;

  // ==========================================================
  // Widths and depths
  localparam int SAMPLE_W   = 24;
  localparam int FIFO_DEPTH = 6;
  localparam int CNT_W      = 3;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int TICK_W     = 8;

  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_TX_LEFT  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_TX_RIGHT = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_RX_LEFT  = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_RX_RIGHT = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_MASK   = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL  = 8'h1c;

  // ==========================================================
  // Field layouts and reset values
  localparam int CTRL_W   = 16;
  localparam int ST_W     = 5;
  localparam int LVL_TXL  = 0;
  localparam int LVL_TXR  = 4;
  localparam int LVL_RXL  = 8;
  localparam int LVL_RXR  = 12;
  localparam int LVL_STATE = 16;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0403;
  localparam logic [ST_W-1:0]   MASK_RESET = 5'h00;

  typedef struct packed {
    logic [TICK_W-1:0] tick_count;
    logic [4:0]        rsvd;
    logic              tick_src;
    logic              rx_reset;
    logic              tx_reset;
  } ctrl_type;

  typedef struct packed {
    logic sample_pair_tick_irq;
    logic rx_unov;
    logic rx_full;
    logic tx_unov;
    logic tx_empty;
  } irq_type;

  typedef enum logic [1:0] {TX_HELD, TX_PENDING, TX_RUN} tx_state_type;

endpackage

//--- design/sample_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 6,
  parameter int CNT_W = 3
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             flush_i,
  input  wire logic             preload_i,
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] data_i,
  input  wire logic             pop_i,
  output logic      [WIDTH-1:0] head_o,
  output logic      [CNT_W-1:0] count_o,
  output logic                  full_o,
  output logic                  empty_o
);

  // ==========================================================
  // Storage
  logic [WIDTH-1:0] mem [DEPTH];
  logic [CNT_W-1:0] rd_reg;
  logic [CNT_W-1:0] wr_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             do_push;
  logic             do_pop;

  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] p);
    bump = (p == CNT_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Push on full and pop on empty are dropped; caller flags them
  assign do_push = push_i && !full_o;
  assign do_pop  = pop_i && !empty_o;
  assign full_o  = (cnt_reg == CNT_W'(DEPTH));
  assign empty_o = (cnt_reg == '0);
  assign count_o = cnt_reg;
  assign head_o  = mem[rd_reg];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_reg  <= '0;
      wr_reg  <= '0;
      cnt_reg <= '0;
    end else if (flush_i) begin
      // Preload leaves one silent sample queued
      rd_reg  <= '0;
      wr_reg  <= preload_i ? CNT_W'(1) : '0;
      cnt_reg <= preload_i ? CNT_W'(1) : '0;
    end else begin
      if (do_push) wr_reg <= bump(wr_reg);
      if (do_pop) rd_reg <= bump(rd_reg);
      if (do_push && !do_pop) cnt_reg <= cnt_reg + 1'b1;
      else if (do_pop && !do_push) cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // Data array has no reset; occupancy guards every read
  always_ff @(posedge clk_i) begin
    if (flush_i && preload_i) mem[0] <= '0;
    else if (!flush_i && do_push) mem[wr_reg] <= data_i;
  end

endmodule // sample_fifo
`default_nettype wire

//--- design/audio_fifo_tick_sequencer.sv
// Operation
// - Released transmit FIFO stays held in reset until the first sample write.
// - A held transmit FIFO contains exactly one remaining sample.
// - First write releases the hold and starts sending on the serial output.
// - Burst of 2, 3 or 4 writes brings occupancy to 3, 4 or 5.
// - Each FIFO stores at most six samples.
// - Empty event when one right sample still remains to send.
// - Underrun event when no sample remains to send.
// - During underrun the last sample is sent again until new data.
// - Tick fires after a programmed number of sample pairs, fill level ignored.
// - Receive FIFOs leave reset only when software clears their reset.
// - Tick uses a selectable source event and a pair count.
// - Tick keeps pulsing while its source FIFO is held in reset.
// - Paths use separate left and right FIFOs; empty needs both.
// - Under/overrun event when either FIFO of a pair under- or overruns.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module audio_fifo_tick_sequencer
  import audio_fifo_pkg::*;
#(
  parameter int SAMPLE_WIDTH = audio_fifo_pkg::SAMPLE_W,
  parameter int DEPTH        = audio_fifo_pkg::FIFO_DEPTH
) (
  input  wire logic                                clk_i,
  input  wire logic                                rstn_i,
  input  wire logic [audio_fifo_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [audio_fifo_pkg::DATA_W-1:0]   wdata_i,
  input  wire logic                                wr_i,
  input  wire logic                                rd_i,
  output logic      [audio_fifo_pkg::DATA_W-1:0]   rdata_o,
  input  wire logic                                word_clk_i,
  input  wire logic [SAMPLE_WIDTH-1:0]             rx_left_i,
  input  wire logic [SAMPLE_WIDTH-1:0]             rx_right_i,
  output logic      [SAMPLE_WIDTH-1:0]             tx_left_o,
  output logic      [SAMPLE_WIDTH-1:0]             tx_right_o,
  output logic                                     tx_active_o,
  output logic                                     irq_o
);
  import audio_fifo_pkg::*;

  // ==========================================================
  // Declarations
  ctrl_type          ctrl_reg;
  irq_type           status_reg;
  irq_type           mask_reg;
  irq_type           ev;
  tx_state_type      tx_state_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [SAMPLE_WIDTH-1:0] txl_out_reg;
  logic [SAMPLE_WIDTH-1:0] txr_out_reg;
  logic              irq_reg;
  logic              tx_active_reg;
  logic [2:0]        wc_sync_reg;
  logic              wc_level_reg;
  logic              wc_rise;
  logic              wc_fall;
  logic [TICK_W-1:0] tick_cnt_reg;
  logic              tick_src_ev;
  logic              tick_hit;
  logic              wr_ctrl;
  logic              wr_txl;
  logic              wr_txr;
  logic              rd_rxl;
  logic              rd_rxr;
  logic              wr_status;
  logic              tx_held;
  logic              tx_run;
  logic              pop_txl;
  logic              pop_txr;
  logic [SAMPLE_WIDTH-1:0] txl_head;
  logic [SAMPLE_WIDTH-1:0] txr_head;
  logic [SAMPLE_WIDTH-1:0] rxl_head;
  logic [SAMPLE_WIDTH-1:0] rxr_head;
  logic [CNT_W-1:0]  txl_cnt;
  logic [CNT_W-1:0]  txr_cnt;
  logic [CNT_W-1:0]  rxl_cnt;
  logic [CNT_W-1:0]  rxr_cnt;
  logic              txl_full;
  logic              txr_full;
  logic              rxl_full;
  logic              rxr_full;
  logic              txl_empty;
  logic              txr_empty;
  logic              rxl_empty;
  logic              rxr_empty;

  function automatic logic [TICK_W-1:0] tick_limit(input logic [TICK_W-1:0] c);
    // A count of zero behaves as one pair per tick
    tick_limit = (c == '0) ? TICK_W'(1) : c;
  endfunction

  function automatic logic [DATA_W-1:0] widen(input logic [SAMPLE_WIDTH-1:0] s);
    widen = DATA_W'(s);
  endfunction

  // ==========================================================
  // Register port decode
  assign wr_ctrl   = wr_i && (addr_i == ADDR_CTRL);
  assign wr_txl    = wr_i && (addr_i == ADDR_TX_LEFT);
  assign wr_txr    = wr_i && (addr_i == ADDR_TX_RIGHT);
  assign wr_status = wr_i && (addr_i == ADDR_STATUS);
  assign rd_rxl    = rd_i && (addr_i == ADDR_RX_LEFT);
  assign rd_rxr    = rd_i && (addr_i == ADDR_RX_RIGHT);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_reg <= CTRL_RESET;
      mask_reg <= MASK_RESET;
    end else begin
      if (wr_ctrl) ctrl_reg <= ctrl_type'(wdata_i[CTRL_W-1:0]);
      if (wr_i && (addr_i == ADDR_MASK)) mask_reg <= irq_type'(wdata_i[ST_W-1:0]);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_reg <= '0;
    end else if (rd_i) begin
      if (addr_i == ADDR_CTRL) begin
        rdata_reg <= DATA_W'(ctrl_reg);
      end else if (addr_i == ADDR_RX_LEFT) begin
        rdata_reg <= rxl_empty ? '0 : widen(rxl_head);
      end else if (addr_i == ADDR_RX_RIGHT) begin
        rdata_reg <= rxr_empty ? '0 : widen(rxr_head);
      end else if (addr_i == ADDR_STATUS) begin
        rdata_reg <= DATA_W'(status_reg);
      end else if (addr_i == ADDR_MASK) begin
        rdata_reg <= DATA_W'(mask_reg);
      end else if (addr_i == ADDR_LEVEL) begin
        rdata_reg <= (DATA_W'(txl_cnt) << LVL_TXL) | (DATA_W'(txr_cnt) << LVL_TXR)
                   | (DATA_W'(rxl_cnt) << LVL_RXL) | (DATA_W'(rxr_cnt) << LVL_RXR)
                   | (DATA_W'(tx_state_reg) << LVL_STATE);
      end else begin
        rdata_reg <= '0;
      end
    end else begin
      rdata_reg <= '0;
    end
  end

  // ==========================================================
  // Word clock synchroniser
  // Edge counts only once stages two and three agree
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wc_sync_reg  <= '0;
      wc_level_reg <= 1'b0;
    end else begin
      wc_sync_reg <= {wc_sync_reg[1:0], word_clk_i};
      if (wc_sync_reg[1] == wc_sync_reg[2]) wc_level_reg <= wc_sync_reg[2];
    end
  end

  // Rising half of the word clock carries left, falling half right
  assign wc_rise = (wc_sync_reg[1] == wc_sync_reg[2]) && wc_sync_reg[2] && !wc_level_reg;
  assign wc_fall = (wc_sync_reg[1] == wc_sync_reg[2]) && !wc_sync_reg[2] && wc_level_reg;

  // ==========================================================
  // Transmit hold sequence
  assign tx_held = (tx_state_reg == TX_HELD);
  assign tx_run  = (tx_state_reg == TX_RUN);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_state_reg <= TX_HELD;
    end else begin
      case (tx_state_reg)
        TX_HELD: begin
          if (!ctrl_reg.tx_reset) tx_state_reg <= TX_PENDING;
        end
        TX_PENDING: begin
          if (ctrl_reg.tx_reset) tx_state_reg <= TX_HELD;
          else if (wr_txl || wr_txr) tx_state_reg <= TX_RUN;
        end
        TX_RUN: begin
          if (ctrl_reg.tx_reset) tx_state_reg <= TX_HELD;
        end
        default: begin
          tx_state_reg <= TX_HELD;
        end
      endcase
    end
  end

  // Flag tracks the next state so the pin rises with the state itself
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_active_reg <= 1'b0;
    end else begin
      tx_active_reg <= !ctrl_reg.tx_reset && (tx_run || ((tx_state_reg == TX_PENDING) && (wr_txl || wr_txr)));
    end
  end

  // ==========================================================
  // FIFO pairs
  // Nothing leaves the FIFO before the first write of the handler
  assign pop_txl = tx_run && wc_rise;
  assign pop_txr = tx_run && wc_fall;

  // Releasing reset preloads one silent sample into each side
  sample_fifo #(.WIDTH(SAMPLE_WIDTH), .DEPTH(DEPTH), .CNT_W(CNT_W)) u_tx_left (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .flush_i  (tx_held),
    .preload_i(!ctrl_reg.tx_reset),
    .push_i   (wr_txl && !tx_held),
    .data_i   (wdata_i[SAMPLE_WIDTH-1:0]),
    .pop_i    (pop_txl),
    .head_o   (txl_head),
    .count_o  (txl_cnt),
    .full_o   (txl_full),
    .empty_o  (txl_empty)
  );

  sample_fifo #(.WIDTH(SAMPLE_WIDTH), .DEPTH(DEPTH), .CNT_W(CNT_W)) u_tx_right (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .flush_i  (tx_held),
    .preload_i(!ctrl_reg.tx_reset),
    .push_i   (wr_txr && !tx_held),
    .data_i   (wdata_i[SAMPLE_WIDTH-1:0]),
    .pop_i    (pop_txr),
    .head_o   (txr_head),
    .count_o  (txr_cnt),
    .full_o   (txr_full),
    .empty_o  (txr_empty)
  );

  // Receive side has no automatic release
  sample_fifo #(.WIDTH(SAMPLE_WIDTH), .DEPTH(DEPTH), .CNT_W(CNT_W)) u_rx_left (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .flush_i  (ctrl_reg.rx_reset),
    .preload_i(1'b0),
    .push_i   (wc_rise),
    .data_i   (rx_left_i),
    .pop_i    (rd_rxl),
    .head_o   (rxl_head),
    .count_o  (rxl_cnt),
    .full_o   (rxl_full),
    .empty_o  (rxl_empty)
  );

  sample_fifo #(.WIDTH(SAMPLE_WIDTH), .DEPTH(DEPTH), .CNT_W(CNT_W)) u_rx_right (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .flush_i  (ctrl_reg.rx_reset),
    .preload_i(1'b0),
    .push_i   (wc_fall),
    .data_i   (rx_right_i),
    .pop_i    (rd_rxr),
    .head_o   (rxr_head),
    .count_o  (rxr_cnt),
    .full_o   (rxr_full),
    .empty_o  (rxr_empty)
  );

  // ==========================================================
  // Serial sample outputs
  // An empty pop leaves the output alone, so the last sample repeats
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      txl_out_reg <= '0;
      txr_out_reg <= '0;
    end else begin
      if (pop_txl && !txl_empty) txl_out_reg <= txl_head;
      if (pop_txr && !txr_empty) txr_out_reg <= txr_head;
    end
  end

  // ==========================================================
  // Sample pair tick
  assign tick_src_ev = ctrl_reg.tick_src ? wc_fall : wc_rise;
  assign tick_hit    = tick_src_ev && (tick_cnt_reg >= tick_limit(ctrl_reg.tick_count) - 1'b1);

  // Counts word clock edges, not FIFO traffic, so reset never stops it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_cnt_reg <= '0;
    end else if (wr_ctrl || tick_hit) begin
      tick_cnt_reg <= '0;
    end else if (tick_src_ev) begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  // ==========================================================
  // Events and interrupt
  always_comb begin
    ev = '0;
    // Left goes out first; after it only one right sample is left
    ev.tx_empty = pop_txl && (txl_cnt == CNT_W'(1)) && (txr_cnt == CNT_W'(1));
    ev.tx_unov  = (pop_txl && txl_empty) || (pop_txr && txr_empty)
                || (wr_txl && !tx_held && txl_full) || (wr_txr && !tx_held && txr_full);
    ev.rx_full  = !ctrl_reg.rx_reset && rxl_full && rxr_full;
    ev.rx_unov  = (rd_rxl && rxl_empty) || (rd_rxr && rxr_empty)
                || (wc_rise && rxl_full) || (wc_fall && rxr_full);
    ev.sample_pair_tick_irq = tick_hit;
  end

  // A new event wins over a clear written in the same cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~(wr_status ? irq_type'(wdata_i[ST_W-1:0]) : irq_type'('0))) | ev;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  assign rdata_o     = rdata_reg;
  assign tx_left_o   = txl_out_reg;
  assign tx_right_o  = txr_out_reg;
  assign tx_active_o = tx_active_reg;
  assign irq_o       = irq_reg;

  // ==========================================================
  // Checks
  chk_pending_stays_held: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (tx_state_reg == TX_PENDING) && !wr_txl && !wr_txr && !ctrl_reg.tx_reset |=> (tx_state_reg == TX_PENDING))
    else $error("transmit FIFO left hold without a write");

  chk_pending_one_sample: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (tx_state_reg == TX_PENDING) |-> (txl_cnt == CNT_W'(1)) && (txr_cnt == CNT_W'(1)))
    else $error("held transmit FIFO does not hold one sample");

  chk_first_write_runs: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (tx_state_reg == TX_PENDING) && wr_txl && !ctrl_reg.tx_reset |=> tx_run ##0 tx_active_o)
    else $error("first write did not start transmission");

  chk_burst_fill: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (tx_state_reg == TX_PENDING) && wr_txl && !ctrl_reg.tx_reset ##1 (wr_txl && !pop_txl && !ctrl_reg.tx_reset)
    |=> (txl_cnt == CNT_W'(3)))
    else $error("burst of two did not give three samples");

  chk_depth_limit: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (txl_cnt <= CNT_W'(DEPTH)) && (rxr_cnt <= CNT_W'(DEPTH)))
    else $error("FIFO occupancy above six");

  chk_empty_event: assert property (@(posedge clk_i) disable iff (!rstn_i)
    pop_txl && (txl_cnt == CNT_W'(1)) && (txr_cnt == CNT_W'(1)) |=> status_reg.tx_empty ##1 irq_o || !mask_reg.tx_empty)
    else $error("empty event missing with one right sample left");

  chk_underrun_repeat: assert property (@(posedge clk_i) disable iff (!rstn_i)
    pop_txl && txl_empty |=> status_reg.tx_unov && $stable(tx_left_o))
    else $error("underrun not flagged or sample not repeated");

  chk_tick_period: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tick_hit && !wr_ctrl |=> status_reg.sample_pair_tick_irq && (tick_cnt_reg == '0))
    else $error("tick not raised or counter not restarted");

  chk_tick_in_reset: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tick_src_ev && !tick_hit && !wr_ctrl |=> (tick_cnt_reg == $past(tick_cnt_reg) + 1'b1))
    else $error("tick counter stalled");

  chk_count_restart: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_ctrl |=> (tick_cnt_reg == '0))
    else $error("tick counter not restarted on count change");

  chk_rx_manual: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ctrl_reg.rx_reset && !wr_ctrl |=> ctrl_reg.rx_reset && (rxl_cnt == '0))
    else $error("receive FIFO left reset by itself");

endmodule // audio_fifo_tick_sequencer
`default_nettype wire

//--- verification/audio_side_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Audio side: word clock and received samples
module audio_side_model #(
  parameter int HALF = 16
) (
  input  wire logic        clk_i,
  output logic             word_clk_o,
  output logic [23:0]      rx_left_o,
  output logic [23:0]      rx_right_o
);
  initial begin
    word_clk_o = 1'b0;
    rx_left_o  = 24'h000000;
    rx_right_o = 24'h000000;
  end

  task automatic set_rx(input logic [23:0] l, input logic [23:0] r);
    rx_left_o  <= l;
    rx_right_o <= r;
  endtask

  // Clock stands low between bursts, so pair counts stay exact
  task automatic run(input int n);
    repeat (n) begin
      @(posedge clk_i);
      word_clk_o <= 1'b1;
      repeat (HALF) @(posedge clk_i);
      word_clk_o <= 1'b0;
      repeat (HALF - 1) @(posedge clk_i);
    end
    // Let the three sync stages settle
    repeat (8) @(posedge clk_i);
  endtask
endmodule // audio_side_model
`default_nettype wire

//--- verification/audio_fifo_tick_sequencer_test.sv
`timescale 1ns/1ns
`default_nettype none
module audio_fifo_tick_sequencer_test;
  import audio_fifo_pkg::*;
  logic              clk_i;
  logic              rstn_i;
  logic [7:0]        addr_i;
  logic [31:0]       wdata_i;
  logic              wr_i;
  logic              rd_i;
  logic [31:0]       rdata_o;
  logic              word_clk;
  logic [23:0]       rx_left;
  logic [23:0]       rx_right;
  logic [23:0]       tx_left_o;
  logic [23:0]       tx_right_o;
  logic              tx_active_o;
  logic              irq_o;
  int                err_count;
  int                samples_checked;
  logic [31:0]       exp_q[$];
  logic              rd_pend;
  logic [23:0]       lastl;
  logic [23:0]       lastr;
  logic [23:0]       rl;
  logic [23:0]       rr;

  audio_fifo_tick_sequencer uut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .word_clk_i(word_clk), .rx_left_i(rx_left),
    .rx_right_i(rx_right), .tx_left_o(tx_left_o), .tx_right_o(tx_right_o),
    .tx_active_o(tx_active_o), .irq_o(irq_o));
  audio_side_model model (.clk_i(clk_i), .word_clk_o(word_clk), .rx_left_o(rx_left), .rx_right_o(rx_right));

  // ==========================================================
  // Clock, comparison and bus tasks
  initial clk_i = 1'b0;
  always #25 clk_i = ~clk_i;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(negedge clk_i) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) check("read queue", 32'h1, 32'h0);
      else check("rdata", rdata_o, exp_q.pop_front());
    end
    rd_pend = (rd_i === 1'b1);
  end

  task automatic summarize();
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole sequence is about 480 cycles
  initial begin
    #(50 * 8000);
    err_count++;
    summarize();
  end

  // ==========================================================
  // Main sequence
  initial begin
    err_count = 0;
    samples_checked = 0;
    rd_pend = 1'b0;
    rstn_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h00000000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    void'($urandom(56));
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(ADDR_CTRL, 32'h00000403);
    rd(ADDR_MASK, 32'h00000000);
    rd(ADDR_LEVEL, 32'h00000000);
    rd(8'h20, 32'h00000000);
    model.run(3);
    rd(ADDR_STATUS, 32'h00000000);
    model.run(1);
    rd(ADDR_STATUS, 32'h00000010);
    wr(ADDR_STATUS, 32'h0000001f);
    wr(ADDR_CTRL, 32'h00000402);
    rd(ADDR_LEVEL, 32'h00010011);
    check("tx_active pending", {31'h0, tx_active_o}, 32'h0);
    // Word clock stands still while the group is written, so no jitter
    for (int i = 0; i < 3; i++) begin
      lastl = 24'($urandom());
      lastr = 24'($urandom());
      wr(ADDR_TX_LEFT, {8'h00, lastl});
      wr(ADDR_TX_RIGHT, {8'h00, lastr});
    end
    check("tx_active run", {31'h0, tx_active_o}, 32'h1);
    rd(ADDR_LEVEL, 32'h00020044);
    model.run(6);
    check("tx_left hold", {8'h00, tx_left_o}, {8'h00, lastl});
    check("tx_right hold", {8'h00, tx_right_o}, {8'h00, lastr});
    rd(ADDR_STATUS, 32'h00000013);
    check("irq masked", {31'h0, irq_o}, 32'h0);
    wr(ADDR_MASK, 32'h00000002);
    repeat (2) @(posedge clk_i);
    check("irq raised", {31'h0, irq_o}, 32'h1);
    wr(ADDR_STATUS, 32'h00000002);
    repeat (2) @(posedge clk_i);
    check("irq cleared", {31'h0, irq_o}, 32'h0);
    rl = 24'($urandom());
    rr = 24'($urandom());
    model.set_rx(rl, rr);
    wr(ADDR_CTRL, 32'h00000400);
    model.run(2);
    rd(ADDR_RX_LEFT, {8'h00, rl});
    rd(ADDR_RX_LEFT, {8'h00, rl});
    rd(ADDR_RX_LEFT, 32'h00000000);
    rd(ADDR_RX_RIGHT, {8'h00, rr});
    // Tick and empty bits stay sticky; transmit keeps underrunning
    rd(ADDR_STATUS, 32'h0000001b);
    repeat (4) @(posedge clk_i);
    summarize();
  end
endmodule // audio_fifo_tick_sequencer_test
`default_nettype wire
